// ==== hdl/lrb_params.svh ====
`ifndef LRB_PARAMS_SVH
`define LRB_PARAMS_SVH
// Functional notes
// - channel-a exponent in bits 15-12 of word 0
// - upper twelve light_fraction_value bits in word 0 low
// - lower eight light_fraction_value bits in word 1 top
// - light_fraction_value is high shifted eight plus low
// - rolling 4-bit sample counter, wraps, bits 7-4
// - check bit 0 is XOR of everything
// - check bit 1 odd bits XOR
// - check bit 2 every fourth bit XOR
// - check bit 3 is light_fraction_value 3,11,19 XOR
// - channel-b words at offsets two and three
// - queued channel-a copy at offsets four, five
// - queued channel-b high word at offset six
// - all fields reset zero, host writes ignored
// ============================================================
// register offsets
`define LRB_OFF_CHA_HIGH   3'h0
`define LRB_OFF_CHA_LOW    3'h1
`define LRB_OFF_CHB_HIGH   3'h2
`define LRB_OFF_CHB_LOW    3'h3
`define LRB_OFF_QCHA_HIGH  3'h4
`define LRB_OFF_QCHA_LOW   3'h5
`define LRB_OFF_QCHB_HIGH  3'h6
// ============================================================
// field positions
`define LRB_EXP_MSB        15
`define LRB_EXP_LSB        12
`define LRB_MHI_MSB        11
`define LRB_MHI_LSB        0
`define LRB_MLO_MSB        15
`define LRB_MLO_LSB        8
`define LRB_SEQ_MSB        7
`define LRB_SEQ_LSB        4
`define LRB_CHK_MSB        3
`define LRB_CHK_LSB        0
`define LRB_MANT_SHIFT     8
// ============================================================
// reset values
`define LRB_WORD_RESET     16'h0000
`define LRB_SEQ_RESET      4'h0
`endif

// ==== hdl/lrb_pkg.sv ====
package lrb_pkg;
  typedef struct packed {
    logic [3:0]  exp;
    logic [19:0] mant;
  } lrb_sample_t;
  typedef struct packed {
    logic [3:0]  exp;
    logic [19:0] mant;
    logic [3:0]  seq;
    logic [3:0]  chk;
  } lrb_result_t;
endpackage

// ==== hdl/lrb_check_code.sv ====
`timescale 1ns/1ps
module lrb_check_code
  import lrb_pkg::*;
(
  input  wire logic [3:0]  i_exp,
  input  wire logic [19:0] i_mant,
  input  wire logic [3:0]  i_seq,
  output logic      [3:0]  o_chk
);
  assign o_chk[0] = ^i_exp ^ (^i_mant) ^ (^i_seq);
  assign o_chk[1] = i_seq[1] ^ i_seq[3] ^ i_mant[1] ^ i_mant[3] ^ i_mant[5] ^ i_mant[7]
                  ^ i_mant[9] ^ i_mant[11] ^ i_mant[13] ^ i_mant[15] ^ i_mant[17]
                  ^ i_mant[19] ^ i_exp[1] ^ i_exp[3];
  assign o_chk[2] = i_seq[3] ^ i_mant[3] ^ i_mant[7] ^ i_mant[11] ^ i_mant[15]
                  ^ i_mant[19] ^ i_exp[3];
  assign o_chk[3] = i_mant[3] ^ i_mant[11] ^ i_mant[19];
endmodule

// ==== hdl/lrb_result_bank.sv ====
`timescale 1ns/1ps
`include "lrb_params.svh"
module lrb_result_bank
  import lrb_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [NCH-1:0]    i_conv_done,
  input  wire lrb_sample_t       i_sample [NCH],
  input  wire logic              i_rd_en,
  input  wire logic [2:0]        i_rd_addr,
  input  wire logic              i_wr_en,
  input  wire logic [2:0]        i_wr_addr,
  input  wire logic [15:0]       i_wr_data,
  output logic      [15:0]       o_rd_data,
  output logic                   o_rd_valid
);
  // ============================================================
  // per-channel result store
  lrb_result_t cur_q  [NCH];
  lrb_result_t qd_q   [NCH];
  logic [3:0]  seq_nx [NCH];
  logic [3:0]  chk_nx [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign seq_nx[c] = cur_q[c].seq + 4'h1;
    lrb_check_code u_chk (
      .i_exp  (i_sample[c].exp),
      .i_mant (i_sample[c].mant),
      .i_seq  (seq_nx[c]),
      .o_chk  (chk_nx[c])
    );
    // fields and checks go in one edge so a read never sees a torn set
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cur_q[c] <= '0;
        qd_q[c]  <= '0;
      end else if (i_conv_done[c]) begin
        qd_q[c]  <= cur_q[c];
        cur_q[c] <= '{exp: i_sample[c].exp, mant: i_sample[c].mant,
                      seq: seq_nx[c], chk: chk_nx[c]};
      end
    end
  end

  // ============================================================
  // word formatting
  function automatic logic [15:0] high_word(input lrb_result_t r);
    high_word = {r.exp, r.mant[19:`LRB_MANT_SHIFT]};
  endfunction
  function automatic logic [15:0] low_word(input lrb_result_t r);
    low_word = {r.mant[`LRB_MANT_SHIFT-1:0], r.seq, r.chk};
  endfunction

  logic [15:0] rd_d;
  always_comb begin
    case (i_rd_addr)
      `LRB_OFF_CHA_HIGH:  rd_d = high_word(cur_q[0]);
      `LRB_OFF_CHA_LOW:   rd_d = low_word(cur_q[0]);
      `LRB_OFF_CHB_HIGH:  rd_d = high_word(cur_q[1]);
      `LRB_OFF_CHB_LOW:   rd_d = low_word(cur_q[1]);
      `LRB_OFF_QCHA_HIGH: rd_d = high_word(qd_q[0]);
      `LRB_OFF_QCHA_LOW:  rd_d = low_word(qd_q[0]);
      `LRB_OFF_QCHB_HIGH: rd_d = high_word(qd_q[1]);
      default:            rd_d = `LRB_WORD_RESET;
    endcase
  end

  // writes are accepted on the port but nothing is stored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data  <= `LRB_WORD_RESET;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_d;
      end
    end
  end

  // ============================================================
  // checks
  wire [3:0] ref_chk = {^{cur_q[0].mant[3], cur_q[0].mant[11], cur_q[0].mant[19]},
                        1'b0, 1'b0, ^{cur_q[0].exp, cur_q[0].mant, cur_q[0].seq}};
  seq_wrap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_conv_done[0] |=> cur_q[0].seq == $past(cur_q[0].seq) + 4'h1)
    else $error("sample counter did not advance");
  chk_b0_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cur_q[0].chk[0] == ref_chk[0])
    else $error("check bit 0 mismatch");
  chk_b3_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cur_q[0].chk[3] == ref_chk[3])
    else $error("check bit 3 mismatch");
  queue_push_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_conv_done[1] |=> qd_q[1] == $past(cur_q[1]))
    else $error("queued copy not pushed");
  hold_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_conv_done[0] |=> $stable(cur_q[0]))
    else $error("result changed without conversion");
  read_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_en && i_rd_addr == `LRB_OFF_CHA_HIGH && !i_conv_done[0]
    |=> o_rd_data == {cur_q[0].exp, cur_q[0].mant[19:8]})
    else $error("high word layout wrong");
  read_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_en && i_rd_addr == `LRB_OFF_CHB_LOW && !i_conv_done[1]
    |=> o_rd_data == {cur_q[1].mant[7:0], cur_q[1].seq, cur_q[1].chk})
    else $error("channel b low word wrong");
  read_queue_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_en && i_rd_addr == `LRB_OFF_QCHB_HIGH && !i_conv_done[1]
    |=> o_rd_data[15:12] == qd_q[1].exp)
    else $error("queued channel b exponent wrong");
  unmapped_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd_en && i_rd_addr == 3'h7 |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  conv_a_c: cover property (@(posedge i_clk) i_conv_done[0] ##1 i_conv_done[0]);
  conv_both_c: cover property (@(posedge i_clk) i_conv_done == 2'b11);
  wr_ign_c: cover property (@(posedge i_clk) i_wr_en && i_conv_done[0]);
  wrap_c: cover property (@(posedge i_clk) cur_q[0].seq == 4'hF && i_conv_done[0]);
endmodule

// ==== tb/lrb_host_model.sv ====
`timescale 1ns/1ps
// =============================
// host side: one-cycle read pulse, address flips to its inverse on every idle cycle
module lrb_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic [2:0] i_addr,
  output logic            o_rd_en,
  output logic [2:0]      o_rd_addr
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_en   <= 1'b0;
      o_rd_addr <= 3'h0;
    end else begin
      o_rd_en   <= i_go;
      o_rd_addr <= i_go ? i_addr : ~o_rd_addr;
    end
  end
endmodule

// ==== tb/lrb_tb_top.sv ====
`timescale 1ns/1ps
module light_result_register_bank_tb_top;
  import lrb_pkg::*;
  logic        clk = 0, rst = 1, go = 0, rd_en, rd_valid, wr_en = 0;
  logic [1:0]  done = 2'h0;
  logic [2:0]  addr = 3'h0, rd_addr, wr_addr = 3'h0;
  logic [15:0] wr_data = 16'h0000, rd_data;
  lrb_sample_t smp [2] = '{default: '0};
  lrb_result_t cur [2], old [2];
  int          err_count = 0, compares = 0, seed = 32'hf68a;
  // =============================
  // design and host model
  lrb_result_bank u_dut (.i_clk(clk), .i_rst(rst), .i_conv_done(done), .i_sample(smp),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
  lrb_host_model u_host (.i_clk(clk), .i_rst(rst), .i_go(go), .i_addr(addr),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr));
  always #25 clk = ~clk;
  // host writes hit the bank on random cycles and must change nothing
  always @(posedge clk) begin
    wr_en   <= $random(seed);
    wr_addr <= $random(seed);
    wr_data <= $random(seed);
  end
  // =============================
  // reference model
  function automatic logic [3:0] chk(lrb_result_t r);
    chk[0] = ^{r.exp, r.mant, r.seq};
    chk[1] = r.seq[1] ^ r.seq[3] ^ r.exp[1] ^ r.exp[3] ^ (^(r.mant & 20'ha_aaaa));
    chk[2] = r.seq[3] ^ r.exp[3] ^ (^(r.mant & 20'h8_8888));
    chk[3] = ^(r.mant & 20'h8_0808);
  endfunction
  function automatic logic [15:0] word(logic [2:0] a);
    lrb_result_t r;
    r = a[2] ? old[a[1]] : cur[a[1]];
    r.chk = chk(r);
    if (a == 3'h7) return 16'h0000;
    return a[0] ? {r.mant[7:0], r.seq, r.chk} : {r.exp, r.mant[19:8]};
  endfunction
  task automatic check(string what, logic [15:0] exp_v, logic [15:0] seen);
    compares++;
    if (seen !== exp_v) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen);
    end
  endtask
  task automatic rd(logic [2:0] a);
    go   <= 1'b1;
    addr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check("rd_valid", 16'h0001, {15'h0000, rd_valid});
    check("rd_data", word(a), rd_data);
  endtask
  task automatic conv(logic [1:0] m);
    lrb_sample_t s [2];
    for (int c = 0; c < 2; c++) begin
      s[c] = lrb_sample_t'(24'($random(seed)));
      smp[c] <= s[c];
      if (m[c]) begin
        old[c] = cur[c];
        cur[c].exp = s[c].exp;
        cur[c].mant = s[c].mant;
        cur[c].seq++;
      end
    end
    done <= m;
    @(posedge clk);
    done <= 2'h0;
  endtask
  task automatic sweep();
    for (int a = 0; a < 8; a++) rd(3'(a));
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // =============================
  // main sequence and watchdog
  initial begin
    cur = '{default: '0};
    old = '{default: '0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sweep();
    for (int i = 0; i < 40; i++) begin
      conv(2'($random(seed)));
      sweep();
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    cur = '{default: '0};
    old = '{default: '0};
    sweep();
    tally_and_finish();
  end
  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
endmodule
